// ### verilog/scp_ctrl.sv
// What this block does
// - Per channel: direct PWM or constant current.
// - Open-load on-state check off in direct mode.
// - Period is M times N; N from 79.
// - M selectable as 32, 64 or 128.
// - M of 512 only in direct mode.
// - Average M samples per period in current mode.
// - Blanking drops samples right after gate edges.
// - Setpoint is 11 bits, 320 mV full scale.
// - PI update once per period, scaled error.
// - Reset, undervoltage, short, direct mode clear integrator.
// - Zero setpoint clears the integrator.
// - Enable low clears integrator unless behaviour set.
// - Battery overvoltage holds the integrator.
// - Phase sync keeps integrator, restarts period.
// - Divider and gain changes leave integrator running.
// - Autozero only at zero setpoint, stores offsets.
// - Autozero lasts four PWM periods.
// - Offsets readable, subtracted when setpoint nonzero.
// - Dither steps setpoint per period, quarter LSB.
// - Triangle uses programmed steps per quarter.
// - New setpoint waits for dither cycle end.
// - New dither settings wait for cycle end.
// - Cycle ends at positive zero crossing.
// - Enable pin disables or freezes all channels.
// - Reset restores defaults and disables channels.
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/10ps
`include "scp_map.svh"

module scp_ctrl
  import scp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire scp_adc_t [7:0] adcSample,
  input wire scp_fault_s faults,
  input wire logic enablePin,
  input wire logic phaseSync,
  output logic [7:0] gateDriveOutput,
  output logic [7:0] openLoadDetEn
);

  scp_state_s s_q;
  scp_state_s s_d;

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic [3:0] mShift(input logic [1:0] sel);
    unique case (sel)
      2'h0: mShift = `SCP_MSH_32;
      2'h1: mShift = `SCP_MSH_64;
      2'h2: mShift = `SCP_MSH_128;
      2'h3: mShift = `SCP_MSH_512;
    endcase
  endfunction

  function automatic logic [22:0] periodLen(input logic [13:0] n,
                                            input logic [1:0] sel);
    periodLen = {9'h0, n} << mShift(sel);
  endfunction

  function automatic logic [8:0] mLast(input logic [1:0] sel);
    mLast = 9'((10'h1 << mShift(sel)) - 10'h1);
  endfunction

  function automatic logic [30:0] clampU(input logic signed [33:0] v,
                                         input logic [30:0] hi);
    if (v < 34'sh0)
      clampU = 31'h0;
    else if (v > $signed({3'h0, hi}))
      clampU = hi;
    else
      clampU = v[30:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  always_comb
  begin
    logic tick;
    logic syncEdge;
    logic periodEnd;
    logic apbDecode;
    logic apbWrite;
    logic chanHit;
    logic globHit;
    logic clearInt;
    logic [2:0] ch;
    logic [2:0] idx;
    logic [22:0] pLen;
    logic [11:0] samp;
    logic [19:0] sumFull;
    logic [10:0] avg;
    logic signed [13:0] tgt;
    logic signed [12:0] err;
    logic signed [33:0] intNew;
    logic signed [33:0] dutyRaw;
    logic [31:0] rd;
    logic [9:0] dLast;
    tick = 1'b0;
    syncEdge = 1'b0;
    periodEnd = 1'b0;
    apbDecode = 1'b0;
    apbWrite = 1'b0;
    chanHit = 1'b0;
    globHit = 1'b0;
    clearInt = 1'b0;
    ch = paddr[`SCP_ADDR_CH];
    idx = paddr[`SCP_ADDR_IDX];
    pLen = '0;
    samp = '0;
    sumFull = '0;
    avg = '0;
    tgt = '0;
    err = '0;
    intNew = '0;
    dutyRaw = '0;
    rd = '0;
    dLast = '0;
    s_d = s_q;

    // Shared N prescaler; one tick per ADC sample slot.
    tick = s_q.tickCnt >= s_q.nDiv - 14'h1;
    s_d.tickCnt = tick ? 14'h0 : s_q.tickCnt + 14'h1;
    syncEdge = phaseSync && !s_q.syncPrev;
    s_d.syncPrev = phaseSync;

    for (int i = 0; i < 8; i++)
    begin
      pLen = periodLen(s_q.nDiv, s_q.chan[i].mSel);
      periodEnd = tick && (s_q.chan[i].sampCnt >= mLast(s_q.chan[i].mSel));
      s_d.chan[i].posCnt = periodEnd ? 23'h0 : s_q.chan[i].posCnt + 23'h1;

      // Sample path with offset removal and blanking.
      samp = {1'b0, adcSample[i]};
      if (s_q.chan[i].spAct != 11'h0)
        samp = (adcSample[i] > s_q.chan[i].azOff) ?
               {1'b0, adcSample[i]} - {1'b0, s_q.chan[i].azOff} : 12'h0;
      if (s_q.blankEn && s_q.chan[i].edgeSeen)
        samp = {1'b0, s_q.chan[i].lastSamp};
      sumFull = s_q.chan[i].sampSum + {8'h0, samp};
      avg = 11'(sumFull >> mShift(s_q.chan[i].mSel));
      if (tick)
      begin
        s_d.chan[i].lastSamp = samp[10:0];
        s_d.chan[i].edgeSeen = 1'b0;
        s_d.chan[i].sampSum = periodEnd ? 20'h0 : sumFull;
        s_d.chan[i].sampCnt = periodEnd ? 9'h0 :
                              s_q.chan[i].sampCnt + 9'h1;
      end

      // Target with dither applied in quarter-LSB units.
      tgt = $signed({3'h0, s_q.chan[i].spAct}) +
            ($signed(s_q.chan[i].dith) >>> `SCP_DITH_SHIFT);
      if (tgt < 14'sh0)
        tgt = 14'sh0;
      else if (tgt > `SCP_SP_MAX)
        tgt = `SCP_SP_MAX;

      // PI update once per period.
      if (periodEnd && s_q.chan[i].ccMode)
      begin
        s_d.chan[i].avgCur = avg;
        err = 13'(tgt - $signed({3'h0, avg}));
        intNew = $signed({3'h0, s_q.chan[i].integ}) +
                 34'($signed({1'b0, s_q.chan[i].intGain})) *
                 34'(err);
        if (faults.batOverVolt)
          intNew = $signed({3'h0, s_q.chan[i].integ});
        s_d.chan[i].integ = clampU(intNew, {pLen, 8'h0});
        dutyRaw = (34'($signed({1'b0, s_q.chan[i].propGain})) * 34'(err) +
                   $signed({3'h0, s_d.chan[i].integ})) >>> `SCP_PER_FRAC;
        s_d.chan[i].duty = 23'(clampU(dutyRaw, {8'h0, pLen}));
      end

      // Dither triangle; pending values load at the zero crossing.
      dLast = 10'({2'h0, s_q.chan[i].quartAct} << 2) - 10'h1;
      if (!s_q.chan[i].ditherEn)
      begin
        s_d.chan[i].spAct = s_q.chan[i].spPend;
        s_d.chan[i].stepAct = s_q.chan[i].stepPend;
        s_d.chan[i].quartAct = s_q.chan[i].quartPend;
        s_d.chan[i].dith = 14'h0;
        s_d.chan[i].dithCnt = 10'h0;
      end
      else if (periodEnd)
      begin
        if (s_q.chan[i].quartAct == 8'h0 || s_q.chan[i].dithCnt >= dLast)
        begin
          s_d.chan[i].dith = 14'h0;
          s_d.chan[i].dithCnt = 10'h0;
          s_d.chan[i].spAct = s_q.chan[i].spPend;
          s_d.chan[i].stepAct = s_q.chan[i].stepPend;
          s_d.chan[i].quartAct = s_q.chan[i].quartPend;
        end
        else
        begin
          s_d.chan[i].dithCnt = s_q.chan[i].dithCnt + 10'h1;
          if (s_q.chan[i].dithCnt < {2'h0, s_q.chan[i].quartAct} ||
              s_q.chan[i].dithCnt >= 10'({2'h0, s_q.chan[i].quartAct} * 3))
            s_d.chan[i].dith = s_q.chan[i].dith +
                               {9'h0, s_q.chan[i].stepAct};
          else
            s_d.chan[i].dith = s_q.chan[i].dith -
                               {9'h0, s_q.chan[i].stepAct};
        end
      end

      // Autozero: wait for a boundary, then four whole periods.
      unique case (s_q.chan[i].azState)
        AZ_IDLE:
          s_d.chan[i].azState = AZ_IDLE;
        AZ_WAIT:
          if (periodEnd)
          begin
            s_d.chan[i].azState = AZ_RUN;
            s_d.chan[i].azPer = 2'h0;
            s_d.chan[i].azSum = 13'h0;
          end
        AZ_RUN:
          if (periodEnd)
          begin
            s_d.chan[i].azSum = s_q.chan[i].azSum + {2'h0, avg};
            s_d.chan[i].azPer = s_q.chan[i].azPer + 2'h1;
            if (s_q.chan[i].azPer == `SCP_AZ_LAST)
            begin
              s_d.chan[i].azOff = 11'((s_q.chan[i].azSum + {2'h0, avg})
                                      >> `SCP_AZ_SHIFT);
              s_d.chan[i].azState = AZ_IDLE;
            end
          end
      endcase

      // Phase sync restarts the period; the integrator is untouched.
      if (syncEdge)
      begin
        s_d.chan[i].posCnt = 23'h0;
        s_d.chan[i].sampCnt = 9'h0;
        s_d.chan[i].sampSum = 20'h0;
      end
    end
    if (syncEdge)
      s_d.tickCnt = 14'h0;

    // APB slave: decode in the first access cycle, complete in the second.
    apbDecode = psel && penable && !s_q.pready;
    apbWrite = psel && penable && pwrite && s_q.pready;
    chanHit = paddr[`SCP_ADDR_HI] == `SCP_CHAN_HI && idx <= `SCP_IDX_STAT;
    globHit = paddr[`SCP_ADDR_WORD] == `SCP_GLOB_WORD;
    if (globHit)
    begin
      rd[`SCP_GLOB_N] = s_q.nDiv;
      rd[`SCP_GLOB_BLANK] = s_q.blankEn;
      rd[`SCP_GLOB_ENB] = s_q.enBehav;
    end
    else if (chanHit)
      unique case (idx)
        `SCP_IDX_CTRL:
        begin
          rd[`SCP_CTRL_CC] = s_q.chan[ch].ccMode;
          rd[`SCP_CTRL_MSEL] = s_q.chan[ch].mSel;
          rd[`SCP_CTRL_DITH] = s_q.chan[ch].ditherEn;
        end
        `SCP_IDX_GAIN:
        begin
          rd[`SCP_GAIN_KP] = s_q.chan[ch].propGain;
          rd[`SCP_GAIN_KI] = s_q.chan[ch].intGain;
        end
        `SCP_IDX_SETP:
          rd[`SCP_SETP] = s_q.chan[ch].spPend;
        `SCP_IDX_DITH:
        begin
          rd[`SCP_DITH_STEP] = s_q.chan[ch].stepPend;
          rd[`SCP_DITH_QUART] = s_q.chan[ch].quartPend;
        end
        `SCP_IDX_DUTY:
          rd[`SCP_DUTY] = s_q.chan[ch].duty;
        `SCP_IDX_AZ:
        begin
          rd[`SCP_AZ_OFF] = s_q.chan[ch].azOff;
          rd[`SCP_AZ_BUSY] = s_q.chan[ch].azState != AZ_IDLE;
        end
        `SCP_IDX_STAT:
        begin
          rd[`SCP_STAT_AVG] = s_q.chan[ch].avgCur;
          rd[`SCP_STAT_GATE] = s_q.chan[ch].gate;
        end
        default:
          rd = '0;
      endcase
    s_d.pready = apbDecode;
    s_d.prdata = apbDecode ? rd : 32'h0;
    s_d.pslverr = apbDecode && !(chanHit || globHit);

    if (apbWrite && globHit)
    begin
      if (pwdata[`SCP_GLOB_N] >= `SCP_N_MIN)
        s_d.nDiv = pwdata[`SCP_GLOB_N];
      s_d.blankEn = pwdata[`SCP_GLOB_BLANK];
      s_d.enBehav = pwdata[`SCP_GLOB_ENB];
    end
    if (apbWrite && chanHit)
      unique case (idx)
        `SCP_IDX_CTRL:
          if (!(pwdata[`SCP_CTRL_CC] &&
                pwdata[`SCP_CTRL_MSEL] == `SCP_MSEL_512))
          begin
            s_d.chan[ch].ccMode = pwdata[`SCP_CTRL_CC];
            s_d.chan[ch].mSel = pwdata[`SCP_CTRL_MSEL];
            s_d.chan[ch].ditherEn = pwdata[`SCP_CTRL_DITH];
          end
        `SCP_IDX_GAIN:
        begin
          s_d.chan[ch].propGain = pwdata[`SCP_GAIN_KP];
          s_d.chan[ch].intGain = pwdata[`SCP_GAIN_KI];
        end
        `SCP_IDX_SETP:
          s_d.chan[ch].spPend = pwdata[`SCP_SETP];
        `SCP_IDX_DITH:
        begin
          s_d.chan[ch].stepPend = pwdata[`SCP_DITH_STEP];
          s_d.chan[ch].quartPend = pwdata[`SCP_DITH_QUART];
        end
        `SCP_IDX_DUTY:
          if (!s_q.chan[ch].ccMode)
            s_d.chan[ch].duty = pwdata[`SCP_DUTY];
        `SCP_IDX_AZ:
          if (pwdata[`SCP_AZ_GO] && s_q.chan[ch].spAct == 11'h0 &&
              s_q.chan[ch].spPend == 11'h0 &&
              s_q.chan[ch].azState == AZ_IDLE)
            s_d.chan[ch].azState = AZ_WAIT;
        default:
          s_d.chan[ch] = s_d.chan[ch];
      endcase

    // Integrator clear events, gate generation and enable handling.
    for (int i = 0; i < 8; i++)
    begin
      clearInt = faults.digitalSupplyUv || faults.analogSupplyUv ||
                 faults.shortToBat[i] || !s_d.chan[i].ccMode;
      clearInt = clearInt || s_d.chan[i].spAct == 11'h0;
      clearInt = clearInt || (!enablePin && !s_q.enBehav);
      if (clearInt)
        s_d.chan[i].integ = 31'h0;
      if (s_d.chan[i].ccMode && s_d.chan[i].duty >
          periodLen(s_d.nDiv, s_d.chan[i].mSel))
        s_d.chan[i].duty = periodLen(s_d.nDiv, s_d.chan[i].mSel);
      s_d.chan[i].gate = s_d.chan[i].posCnt < s_d.chan[i].duty;
      if (!enablePin)
        s_d.chan[i].gate = s_q.enBehav && s_q.chan[i].gate;
      if (s_d.chan[i].gate != s_q.chan[i].gate)
        s_d.chan[i].edgeSeen = 1'b1;
      s_d.gateOut[i] = s_d.chan[i].gate;
      s_d.olEn[i] = s_d.chan[i].ccMode;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_q <= '0;
      s_q.nDiv <= `SCP_N_RST;
    end
    else
      s_q <= s_d;
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign gateDriveOutput = s_q.gateOut;
  assign openLoadDetEn = s_q.olEn;

  ////////////////////////////////////////////////////////////////////////////

  scp_chan_s c0;
  logic c0End;
  logic c0Clear;
  assign c0 = s_q.chan[0];
  assign c0End = s_q.tickCnt >= s_q.nDiv - 14'h1 &&
                 c0.sampCnt >= mLast(c0.mSel) && !(phaseSync && !s_q.syncPrev);
  assign c0Clear = faults.digitalSupplyUv || faults.analogSupplyUv ||
                   faults.shortToBat[0] || !c0.ccMode || c0.spAct == 11'h0 ||
                   (!enablePin && !s_q.enBehav);

  property p_no512cc;
    @(posedge clk_sys) disable iff (sys_rst)
    !(c0.ccMode && c0.mSel == `SCP_MSEL_512);
  endproperty
  a_no512cc: assert property (p_no512cc)
    else $error("Divider 512 active in current mode.");

  property p_olen;
    @(posedge clk_sys) disable iff (sys_rst)
    openLoadDetEn[0] == c0.ccMode;
  endproperty
  a_olen: assert property (p_olen)
    else $error("Open-load enable does not follow mode.");

  property p_nmin;
    @(posedge clk_sys) disable iff (sys_rst)
    s_q.nDiv >= `SCP_N_MIN;
  endproperty
  a_nmin: assert property (p_nmin)
    else $error("Period divider below minimum.");

  property p_dutysat;
    @(posedge clk_sys) disable iff (sys_rst)
    c0.ccMode |-> c0.duty <= periodLen(s_q.nDiv, c0.mSel);
  endproperty
  a_dutysat: assert property (p_dutysat)
    else $error("Duty exceeds one period.");

  property p_hold;
    @(posedge clk_sys) disable iff (sys_rst)
    faults.batOverVolt && !c0Clear && c0.ccMode |=> $stable(c0.integ);
  endproperty
  a_hold: assert property (p_hold)
    else $error("Integrator moved during overvoltage.");

  property p_short;
    @(posedge clk_sys) disable iff (sys_rst)
    faults.shortToBat[0] |=> c0.integ == 31'h0;
  endproperty
  a_short: assert property (p_short)
    else $error("Integrator not cleared on short.");

  property p_az;
    @(posedge clk_sys) disable iff (sys_rst)
    c0.azState == AZ_RUN && c0End && c0.azPer == `SCP_AZ_LAST |=>
      c0.azState == AZ_IDLE;
  endproperty
  a_az: assert property (p_az)
    else $error("Autozero did not end after four periods.");

  property p_ditherWait;
    @(posedge clk_sys) disable iff (sys_rst)
    c0.ditherEn && !c0End |=> c0.spAct == $past(c0.spAct);
  endproperty
  a_ditherWait: assert property (p_ditherWait)
    else $error("Setpoint changed inside a dither cycle.");

  property p_disable;
    @(posedge clk_sys) disable iff (sys_rst)
    !enablePin && !s_q.enBehav |=> gateDriveOutput == 8'h0;
  endproperty
  a_disable: assert property (p_disable)
    else $error("Gate driven while disabled.");

endmodule

// ### common/scp_map.svh
`ifndef SCP_MAP_SVH
`define SCP_MAP_SVH

`define SCP_N_MIN 14'd79
`define SCP_N_RST 14'd79
`define SCP_PER_FRAC 8
`define SCP_AZ_LAST 2'd3
`define SCP_AZ_SHIFT 2
`define SCP_DITH_SHIFT 2
`define SCP_SP_MAX 14'sd2047

`define SCP_MSH_32 4'd5
`define SCP_MSH_64 4'd6
`define SCP_MSH_128 4'd7
`define SCP_MSH_512 4'd9
`define SCP_MSEL_512 2'h3

`define SCP_ADDR_HI 11:8
`define SCP_ADDR_CH 7:5
`define SCP_ADDR_IDX 4:2
`define SCP_ADDR_WORD 11:2
`define SCP_CHAN_HI 4'h0
`define SCP_GLOB_WORD 10'h040

`define SCP_IDX_CTRL 3'h0
`define SCP_IDX_GAIN 3'h1
`define SCP_IDX_SETP 3'h2
`define SCP_IDX_DITH 3'h3
`define SCP_IDX_DUTY 3'h4
`define SCP_IDX_AZ 3'h5
`define SCP_IDX_STAT 3'h6

`define SCP_CTRL_CC 0
`define SCP_CTRL_MSEL 2:1
`define SCP_CTRL_DITH 3
`define SCP_GAIN_KP 7:0
`define SCP_GAIN_KI 15:8
`define SCP_SETP 10:0
`define SCP_DITH_STEP 4:0
`define SCP_DITH_QUART 15:8
`define SCP_DUTY 22:0
`define SCP_AZ_GO 0
`define SCP_AZ_OFF 10:0
`define SCP_AZ_BUSY 16
`define SCP_STAT_AVG 10:0
`define SCP_STAT_GATE 16
`define SCP_GLOB_N 13:0
`define SCP_GLOB_BLANK 16
`define SCP_GLOB_ENB 17

`endif

// ### common/scp_pkg.sv
package scp_pkg;

  typedef logic [10:0] scp_adc_t;

  typedef enum logic [1:0] {AZ_IDLE, AZ_WAIT, AZ_RUN} scp_az_e;

  typedef struct packed {
    logic digitalSupplyUv;
    logic analogSupplyUv;
    logic batOverVolt;
    logic [7:0] shortToBat;
  } scp_fault_s;

  typedef struct packed {
    logic ccMode;
    logic [1:0] mSel;
    logic ditherEn;
    logic [7:0] propGain;
    logic [7:0] intGain;
    logic [10:0] spPend;
    logic [10:0] spAct;
    logic [4:0] stepPend;
    logic [4:0] stepAct;
    logic [7:0] quartPend;
    logic [7:0] quartAct;
    logic [13:0] dith;
    logic [9:0] dithCnt;
    logic [8:0] sampCnt;
    logic [22:0] posCnt;
    logic [19:0] sampSum;
    logic [10:0] lastSamp;
    logic [10:0] avgCur;
    logic edgeSeen;
    logic [30:0] integ;
    logic [22:0] duty;
    logic gate;
    scp_az_e azState;
    logic [1:0] azPer;
    logic [12:0] azSum;
    logic [10:0] azOff;
  } scp_chan_s;

  typedef struct packed {
    scp_chan_s [7:0] chan;
    logic [13:0] nDiv;
    logic blankEn;
    logic enBehav;
    logic syncPrev;
    logic [13:0] tickCnt;
    logic [7:0] gateOut;
    logic [7:0] olEn;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } scp_state_s;

endpackage

// ### tb/scp_load_model.sv
`timescale 1ns/10ps
module scp_load_model
  import scp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [7:0] gateDriveOutput,
  input wire logic fixEn,
  input wire logic [10:0] fixVal,
  output scp_adc_t [7:0] adcSample
);
  // Coil current ramps up while the gate is on and decays while off.
  logic [10:0] coil [8];
  initial
  begin
    for (int i = 0; i < 8; i++)
      coil[i] = 11'h000;
  end
  always @(posedge clk_sys)
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (gateDriveOutput[i] && coil[i] < 11'h7f0)
        coil[i] <= coil[i] + 11'h004;
      else if (!gateDriveOutput[i] && coil[i] > 11'h003)
        coil[i] <= coil[i] - 11'h003;
    end
  end
  // A fixed level stands in for the sense path when asked.
  always @*
  begin
    for (int i = 0; i < 8; i++)
      adcSample[i] = fixEn ? fixVal : coil[i];
  end
endmodule

// ### tb/scp_ctrl_tb.sv
`timescale 1ns/10ps
module scp_ctrl_tb
  import scp_pkg::*;
;
  localparam int PER0 = 32 * 79;
  logic clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed, rd;
  scp_adc_t [7:0] adcSample;
  scp_fault_s faults;
  logic enablePin, phaseSync, fixEn;
  logic [10:0] fixVal;
  logic [7:0] gateDriveOutput, openLoadDetEn;
  logic [64:0] expQ[$];
  logic [64:0] ent;
  int cyc, bad_count, check_count, m, d, hiT, per, a, b, t0, k;

  scp_ctrl i_scp_ctrl (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .adcSample(adcSample), .faults(faults), .enablePin(enablePin),
    .phaseSync(phaseSync), .gateDriveOutput(gateDriveOutput),
    .openLoadDetEn(openLoadDetEn));
  scp_load_model i_scp_load_model (.clk_sys(clk_sys),
    .gateDriveOutput(gateDriveOutput), .fixEn(fixEn), .fixVal(fixVal),
    .adcSample(adcSample));

  always #50 clk_sys = ~clk_sys;
  always @(negedge clk_sys) cyc <= cyc + 1;

  ////////////////////////////////////////////////////////////////////////
  task stop_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task tmo();
    bad_count++;
    stop_test();
  endtask
  task check(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    check_count++;
    if (seen !== ex)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function logic [11:0] ad(input int ch, input int idx);
    return 12'(ch * 32 + idx * 4);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // One APB transfer; its expected answer is queued for the monitor.
  task apb(input logic w, input logic [11:0] ad0, input logic [31:0] dt,
    input logic [31:0] msk, input logic er);
    int j;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad0;
    pwdata <= dt;
    expQ.push_back({er, msk, dt & msk});
    @(posedge clk_sys);
    penable <= 1'b1;
    for (j = 0; j < 20; j++)
    begin
      @(posedge clk_sys);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (j == 20)
      tmo();
  endtask
  task wr(input logic [11:0] ad0, input logic [31:0] dt);
    apb(1'b1, ad0, dt, 32'h0, 1'b0);
  endtask
  task rdc(input logic [11:0] ad0, input logic [31:0] ex,
    input logic [31:0] msk);
    apb(1'b0, ad0, ex, msk, 1'b0);
  endtask
  task waitg(input int ch, input logic v);
    int j;
    for (j = 0; j < 12000; j++)
    begin
      @(posedge clk_sys);
      if (gateDriveOutput[ch] === v)
        break;
    end
    if (j == 12000)
      tmo();
  endtask
  task meas(input int ch);
    waitg(ch, 1'b0);
    waitg(ch, 1'b1);
    t0 = cyc;
    waitg(ch, 1'b0);
    hiT = cyc - t0;
    waitg(ch, 1'b1);
    per = cyc - t0;
  endtask

  always @(posedge clk_sys)
  begin
    if (pready === 1'b1)
    begin
      if (expQ.size() == 0)
        check("answer", 32'h1, 32'h0);
      else
      begin
        ent = expQ.pop_front();
        check("prdata", prdata & ent[63:32], ent[31:0]);
        check("pslverr", {31'h0, pslverr}, {31'h0, ent[64]});
      end
    end
  end

  initial
  begin
    repeat (95000) @(posedge clk_sys);
    tmo();
  end

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys = 1'b0;
    sys_rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    faults = '0;
    {enablePin, phaseSync, fixEn, fixVal} = {1'b1, 1'b0, 1'b1, 11'h000};
    {cyc, bad_count, check_count, seed} = {32'h0, 32'h0, 32'h0, 32'd14631};
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    check("gates", {24'h0, gateDriveOutput}, 32'h0);
    check("olEn", {24'h0, openLoadDetEn}, 32'h0);
    rdc(12'h100, 32'h4f, 32'h3ffff);
    rdc(ad(0, 0), 32'h0, 32'hf);
    apb(1'b0, ad(0, 7), 32'h0, 32'hffffffff, 1'b1);
    wr(12'h100, 32'h4e);
    rdc(12'h100, 32'h4f, 32'h3fff);
    for (m = 0; m < 2; m++)
    begin
      d = 1 + xs() % 500;
      wr(ad(0, 0), 32'(m << 1));
      wr(ad(0, 4), 32'(d));
      meas(0);
      meas(0);
      check("period", 32'(per), 32'((32 << m) * 79));
      check("high", 32'(hiT), 32'(d));
    end
    wr(ad(0, 0), 32'h4);
    rdc(ad(0, 0), 32'h4, 32'hf);
    wr(ad(0, 0), 32'h6);
    rdc(ad(0, 0), 32'h6, 32'hf);
    wr(ad(0, 0), 32'h7);
    rdc(ad(0, 0), 32'h6, 32'hf);
    wr(ad(0, 0), 32'h1);
    rdc(ad(0, 0), 32'h1, 32'hf);
    check("olEn0", {31'h0, openLoadDetEn[0]}, 32'h1);
    a = 1 + xs() % 100;
    fixVal <= 11'(a);
    t0 = cyc;
    wr(ad(0, 5), 32'h1);
    rdc(ad(0, 5), 32'h10000, 32'h10000);
    for (k = 0; k < 4000; k++)
    begin
      rdc(ad(0, 5), 32'h0, 32'h0);
      if (rd[16] === 1'b0)
        break;
    end
    if (k == 4000)
      tmo();
    check("azTime", 32'(cyc - t0 >= 4 * PER0 && cyc - t0 <= 5 * PER0 + 40),
      32'h1);
    rdc(ad(0, 5), 32'(a), 32'h7ff);
    b = a + xs() % 300;
    fixVal <= 11'(b);
    wr(ad(0, 2), 32'd500);
    rdc(ad(0, 2), 32'd500, 32'h7ff);
    repeat (3 * PER0) @(posedge clk_sys);
    rdc(ad(0, 6), 32'(b - a), 32'h7ff);
    wr(ad(0, 1), 32'hffff);
    fixVal <= 11'(a);
    wr(ad(0, 2), 32'd2047);
    repeat (4 * PER0) @(posedge clk_sys);
    rdc(ad(0, 4), 32'(PER0), 32'h7fffff);
    wr(ad(0, 4), 32'h5);
    rdc(ad(0, 4), 32'(PER0), 32'h7fffff);
    faults.batOverVolt <= 1'b1;
    repeat (PER0) @(posedge clk_sys);
    rdc(ad(0, 4), 32'(PER0), 32'h7fffff);
    faults.batOverVolt <= 1'b0;
    faults.shortToBat <= 8'h01;
    repeat (3) @(posedge clk_sys);
    faults.shortToBat <= 8'h00;
    enablePin <= 1'b0;
    repeat (3) @(posedge clk_sys);
    check("gateOff", {31'h0, gateDriveOutput[0]}, 32'h0);
    enablePin <= 1'b1;
    wr(ad(0, 2), 32'h0);
    repeat (2 * PER0) @(posedge clk_sys);
    rdc(ad(0, 4), 32'h0, 32'h7fffff);
    stop_test();
  end
endmodule
